// >>> core/dbgm_consts.svh
// Constants of the serial debug command engine: link format, responses,
// opcodes, operand sizes and the register map of the AXI4-Lite slave.
// Assumes a single include per compilation unit; guarded regardless.
`ifndef DBGM_CONSTS_SVH
`define DBGM_CONSTS_SVH

`define DBGM_FRAME_LAST     5'h10
`define DBGM_RSP_NOTREADY   17'h10000
`define DBGM_RSP_BUSERR     17'h10001
`define DBGM_RSP_ILLEGAL    17'h1ffff
`define DBGM_RSP_COMPLETE   17'h0ffff

`define DBGM_OP_NOP         16'h0000
`define DBGM_OP_WRITE       8'h18
`define DBGM_OP_READ        8'h19
`define DBGM_OP_FILL        8'h1c
`define DBGM_OP_DUMP        8'h1d
`define DBGM_OP_REGWR       8'h20
`define DBGM_OP_REGRD       8'h21
`define DBGM_OP_REGSUB      4'h8

`define DBGM_SZ_BYTE        2'h0
`define DBGM_SZ_WORD        2'h1
`define DBGM_SZ_LONG        2'h2
`define DBGM_SZ_RSVD        2'h3
`define DBGM_INC_BYTE       32'h1
`define DBGM_INC_WORD       32'h2
`define DBGM_INC_LONG       32'h4
`define DBGM_ALIGN_WORD     32'hffff_fffe
`define DBGM_ALIGN_LONG     32'hffff_fffc

`define DBGM_REG_ATTR       8'h00
`define DBGM_REG_PTR        8'h04
`define DBGM_REG_STAT       8'h08
`define DBGM_ATTR_RESET     5'h05
`define DBGM_RESP_OKAY      2'h0
`define DBGM_RESP_SLVERR    2'h2

`endif

// >>> core/dbgm_pkg.sv
// Types of the serial debug command engine.
// Constants live in dbgm_consts.svh.
package dbgm_pkg;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_ADDRH = 3'h1,
        ST_ADDRL = 3'h3,
        ST_DATAH = 3'h2,
        ST_DATAL = 3'h6,
        ST_BUSY  = 3'h7,
        ST_RESHI = 3'h5
    } dbgm_state_t;

    typedef enum logic [1:0] {
        LC_OTHER = 2'h0,
        LC_READ  = 2'h1,
        LC_WRITE = 2'h3
    } dbgm_last_t;

    typedef struct packed {
        logic        dsClkMeta;
        logic        dsClkSync;
        logic        dsClkPrev;
        logic        dsInMeta;
        logic        dsInSync;
        logic [4:0]  bitCnt;
        logic [16:0] rxShift;
        logic [16:0] txShift;
        logic [16:0] txNext;
        dbgm_state_t st;
        logic [15:0] cmd;
        logic [31:0] addr;
        logic [15:0] dataHi;
        logic [15:0] resLo;
        logic [31:0] ptr;
        dbgm_last_t  lastCmd;
        logic        memReq;
        logic        memWr;
        logic [31:0] memAddr;
        logic [1:0]  memSize;
        logic [31:0] memWrData;
        logic        regWrEn;
        logic [3:0]  regSel;
        logic [31:0] regWrData;
        logic [4:0]  attr;
        logic        awHeld;
        logic [7:0]  awAddr;
        logic        wHeld;
        logic [31:0] wData;
        logic [3:0]  wStrb;
        logic        bValid;
        logic [1:0]  bResp;
        logic        rValid;
        logic [31:0] rData;
        logic [1:0]  rResp;
    } dbgm_regs_t;

endpackage

// >>> core/dbgm_cmd.sv
// Serial debug command engine: register and memory access over a 17-bit serial link.
// Assumes dsClk/dsIn come from the external host; memory and CPU register ports are on clock.
`timescale 1ns/1ps
`include "dbgm_consts.svh"

module dbgm_cmd
    import dbgm_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        arst_n,
    // AXI4-Lite slave
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Serial debug link
    input  wire logic        dsClk,
    input  wire logic        dsIn,
    output logic             dsOut,
    // CPU register file
    input  wire logic        cpuHalted,
    output logic             regWrEn,
    output logic [3:0]       regSel,
    output logic [31:0]      regWrData,
    input  wire logic [31:0] regRdData,
    // System memory bus
    output logic             memReq,
    output logic             memWr,
    output logic [31:0]      memAddr,
    output logic [1:0]       memSize,
    output logic [4:0]       memAttr,
    output logic [31:0]      memWrData,
    input  wire logic        memDone,
    input  wire logic        memBusErr,
    input  wire logic [31:0] memRdData
);

    dbgm_regs_t r;
    dbgm_regs_t n;

    function automatic logic [31:0] alignAddr(input logic [31:0] a, input logic [1:0] sz);
        logic [31:0] res;
        res = a;
        if (sz == `DBGM_SZ_WORD) begin
            res = a & `DBGM_ALIGN_WORD;
        end else if (sz == `DBGM_SZ_LONG) begin
            res = a & `DBGM_ALIGN_LONG;
        end
        return res;
    endfunction

    function automatic logic [31:0] sizeInc(input logic [1:0] sz);
        logic [31:0] inc;
        inc = `DBGM_INC_BYTE;
        if (sz == `DBGM_SZ_WORD) begin
            inc = `DBGM_INC_WORD;
        end else if (sz == `DBGM_SZ_LONG) begin
            inc = `DBGM_INC_LONG;
        end
        return inc;
    endfunction

    always_comb begin
        logic        rise;
        logic        frame;
        logic [16:0] rxWord;
        logic [7:0]  opHi;
        logic [1:0]  sz;
        logic        sizeOk;
        logic        wrHandled;
        rise      = 1'b0;
        frame     = 1'b0;
        rxWord    = '0;
        opHi      = '0;
        sz        = '0;
        sizeOk    = 1'b0;
        wrHandled = 1'b0;
        n         = r;

        // Link pins pass two flops before anything looks at them
        n.dsClkMeta = dsClk;
        n.dsClkSync = r.dsClkMeta;
        n.dsInMeta  = dsIn;
        n.dsInSync  = r.dsInMeta;
        n.dsClkPrev = r.dsClkSync;
        n.regWrEn   = 1'b0;

        rise = r.dsClkSync & ~r.dsClkPrev;
        if (rise) begin
            rxWord    = {r.rxShift[15:0], r.dsInSync};
            n.rxShift = rxWord;
            if (r.bitCnt == `DBGM_FRAME_LAST) begin
                frame    = 1'b1;
                n.bitCnt = '0;
            end else begin
                n.bitCnt  = r.bitCnt + 5'h1;
                n.txShift = {r.txShift[15:0], 1'b0};
            end
        end

        // Access end: the result goes out in the first frame that starts after it
        if (r.st == ST_BUSY && memDone) begin
            n.memReq = 1'b0;
            n.ptr    = r.memAddr + sizeInc(r.memSize);
            n.st     = ST_IDLE;
            if (memBusErr) begin
                n.txNext = `DBGM_RSP_BUSERR;
            end else if (r.memWr) begin
                n.txNext = `DBGM_RSP_COMPLETE;
            end else if (r.memSize == `DBGM_SZ_LONG) begin
                n.txNext = {1'b0, memRdData[31:16]};
                n.resLo  = memRdData[15:0];
                n.st     = ST_RESHI;
            end else if (r.memSize == `DBGM_SZ_WORD) begin
                n.txNext = {1'b0, memRdData[15:0]};
            end else begin
                n.txNext = {9'h000, memRdData[7:0]};
            end
            // A frame already on the wire began during the access and still reads not ready
            if (!frame && (rise || r.bitCnt != '0)) begin
                n.st = ST_BUSY;
            end else begin
                n.txShift = n.txNext;
            end
        end else if (frame) begin
            opHi   = rxWord[15:8];
            sz     = rxWord[7:6];
            sizeOk = (sz != `DBGM_SZ_RSVD);
            unique case (r.st)
                ST_IDLE: begin
                    n.cmd    = rxWord[15:0];
                    n.txNext = `DBGM_RSP_ILLEGAL;
                    if (rxWord[15:0] == `DBGM_OP_NOP) begin
                        n.txNext = `DBGM_RSP_COMPLETE;
                    end else if (opHi == `DBGM_OP_REGRD && rxWord[7:4] == `DBGM_OP_REGSUB) begin
                        if (cpuHalted) begin
                            n.regSel = rxWord[3:0];
                            n.txNext = `DBGM_RSP_NOTREADY;
                            n.st     = ST_RESHI;
                        end else begin
                            n.txNext = `DBGM_RSP_BUSERR;
                        end
                        n.lastCmd = LC_OTHER;
                    end else if (opHi == `DBGM_OP_REGWR && rxWord[7:4] == `DBGM_OP_REGSUB) begin
                        n.txNext  = `DBGM_RSP_NOTREADY;
                        n.st      = ST_DATAH;
                        n.lastCmd = LC_OTHER;
                    end else if ((opHi == `DBGM_OP_READ || opHi == `DBGM_OP_WRITE)
                                 && rxWord[5:0] == 6'h00 && sizeOk) begin
                        n.txNext = `DBGM_RSP_NOTREADY;
                        n.st     = ST_ADDRH;
                    end else if (opHi == `DBGM_OP_DUMP && rxWord[5:0] == 6'h00 && sizeOk
                                 && r.lastCmd == LC_READ) begin
                        n.txNext    = `DBGM_RSP_NOTREADY;
                        n.memReq    = 1'b1;
                        n.memWr     = 1'b0;
                        n.memSize   = sz;
                        n.memAddr   = alignAddr(r.ptr, sz);
                        n.st        = ST_BUSY;
                    end else if (opHi == `DBGM_OP_FILL && rxWord[5:0] == 6'h00 && sizeOk
                                 && r.lastCmd == LC_WRITE) begin
                        n.txNext = `DBGM_RSP_NOTREADY;
                        n.addr   = r.ptr;
                        n.st     = (sz == `DBGM_SZ_LONG) ? ST_DATAH : ST_DATAL;
                    end
                end
                ST_ADDRH: begin
                    n.addr[31:16] = rxWord[15:0];
                    n.txNext      = `DBGM_RSP_NOTREADY;
                    n.st          = ST_ADDRL;
                end
                ST_ADDRL: begin
                    n.addr[15:0] = rxWord[15:0];
                    n.txNext     = `DBGM_RSP_NOTREADY;
                    if (r.cmd[15:8] == `DBGM_OP_READ) begin
                        n.memReq  = 1'b1;
                        n.memWr   = 1'b0;
                        n.memSize = r.cmd[7:6];
                        n.memAddr = alignAddr({r.addr[31:16], rxWord[15:0]}, r.cmd[7:6]);
                        n.lastCmd = LC_READ;
                        n.st      = ST_BUSY;
                    end else begin
                        n.st = (r.cmd[7:6] == `DBGM_SZ_LONG) ? ST_DATAH : ST_DATAL;
                    end
                end
                ST_DATAH: begin
                    n.dataHi = rxWord[15:0];
                    n.txNext = `DBGM_RSP_NOTREADY;
                    n.st     = ST_DATAL;
                end
                ST_DATAL: begin
                    if (r.cmd[15:8] == `DBGM_OP_REGWR) begin
                        n.st = ST_IDLE;
                        if (cpuHalted) begin
                            n.regWrEn   = 1'b1;
                            n.regSel    = r.cmd[3:0];
                            n.regWrData = {r.dataHi, rxWord[15:0]};
                            n.txNext    = `DBGM_RSP_COMPLETE;
                        end else begin
                            n.txNext = `DBGM_RSP_BUSERR;
                        end
                    end else begin
                        n.txNext  = `DBGM_RSP_NOTREADY;
                        n.memReq  = 1'b1;
                        n.memWr   = 1'b1;
                        n.memSize = r.cmd[7:6];
                        n.memAddr = alignAddr(r.addr, r.cmd[7:6]);
                        n.memWrData = (r.cmd[7:6] == `DBGM_SZ_LONG) ? {r.dataHi, rxWord[15:0]}
                                                                   : {16'h0000, rxWord[15:0]};
                        n.lastCmd = LC_WRITE;
                        n.st      = ST_BUSY;
                    end
                end
                ST_BUSY: begin
                    if (r.memReq) begin
                        n.txNext = `DBGM_RSP_NOTREADY;
                    end else begin
                        n.st = (!r.memWr && r.memSize == `DBGM_SZ_LONG && !r.txNext[16]) ? ST_RESHI : ST_IDLE;
                    end
                end
                ST_RESHI: begin
                    n.txNext = {1'b0, r.resLo};
                    n.st     = ST_IDLE;
                end
                default: begin
                    n.st = ST_IDLE;
                end
            endcase
            // Result of this frame goes out in the next one
            n.txShift = n.txNext;
        end

        // Register file reads through regSel, so its data is caught one cycle after the select moves
        if (r.st == ST_RESHI && r.cmd[15:8] == `DBGM_OP_REGRD && r.bitCnt == '0 && !rise) begin
            n.txNext  = {1'b0, regRdData[31:16]};
            n.resLo   = regRdData[15:0];
            n.txShift = n.txNext;
        end

        // Register slave; one write and one read in flight
        if (awvalid && !r.awHeld && !r.bValid) begin
            n.awHeld = 1'b1;
            n.awAddr = awaddr;
        end
        if (wvalid && !r.wHeld && !r.bValid) begin
            n.wHeld = 1'b1;
            n.wData = wdata;
            n.wStrb = wstrb;
        end
        if (r.awHeld && r.wHeld && !r.bValid) begin
            n.awHeld  = 1'b0;
            n.wHeld   = 1'b0;
            n.bValid  = 1'b1;
            wrHandled = (r.awAddr == `DBGM_REG_ATTR);
            n.bResp   = wrHandled ? `DBGM_RESP_OKAY : `DBGM_RESP_SLVERR;
            if (wrHandled && r.wStrb[0]) begin
                n.attr = r.wData[4:0];
            end
        end else if (r.bValid && bready) begin
            n.bValid = 1'b0;
        end
        if (arvalid && !r.rValid) begin
            n.rValid = 1'b1;
            n.rResp  = `DBGM_RESP_OKAY;
            unique case (araddr)
                `DBGM_REG_ATTR: n.rData = {27'h0, r.attr};
                `DBGM_REG_PTR:  n.rData = r.ptr;
                `DBGM_REG_STAT: n.rData = {24'h0, r.memReq, r.lastCmd, r.st, cpuHalted, 1'b0};
                default: begin
                    n.rData = '0;
                    n.rResp = `DBGM_RESP_SLVERR;
                end
            endcase
        end else if (r.rValid && rready) begin
            n.rValid = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            r         <= '0;
            r.st      <= ST_IDLE;
            r.lastCmd <= LC_OTHER;
            r.txNext  <= `DBGM_RSP_COMPLETE;
            r.txShift <= `DBGM_RSP_COMPLETE;
            r.attr    <= `DBGM_ATTR_RESET;
        end else begin
            r <= n;
        end
    end

    assign awready   = !r.awHeld && !r.bValid;
    assign wready    = !r.wHeld && !r.bValid;
    assign bvalid    = r.bValid;
    assign bresp     = r.bResp;
    assign arready   = !r.rValid;
    assign rvalid    = r.rValid;
    assign rdata     = r.rData;
    assign rresp     = r.rResp;
    assign dsOut     = r.txShift[16];
    assign regWrEn   = r.regWrEn;
    assign regSel    = r.regSel;
    assign regWrData = r.regWrData;
    assign memReq    = r.memReq;
    assign memWr     = r.memWr;
    assign memAddr   = r.memAddr;
    assign memSize   = r.memSize;
    assign memAttr   = r.attr;
    assign memWrData = r.memWrData;

endmodule

// >>> verif/dbgm_cmd_monitor.sv
// Checker of the debug engine's memory, register and attribute outputs.
// Assumes it is bound to dbgm_cmd and sees only its ports.
`timescale 1ns/1ps

module dbgm_cmd_monitor (
    // Clock and reset
    input wire logic        clock,
    input wire logic        arst_n,
    // Register side
    input wire logic        wvalid,
    input wire logic        cpuHalted,
    input wire logic        regWrEn,
    // Memory side
    input wire logic        memReq,
    input wire logic        memDone,
    input wire logic [1:0]  memSize,
    input wire logic [31:0] memAddr,
    input wire logic [4:0]  memAttr
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    sequence s_waiting;
        memReq && !memDone;
    endsequence
    sequence s_released;
        memReq && memDone ##1 !memReq;
    endsequence

    a_word_align: assert property (memReq && memSize == 2'h1 |-> !memAddr[0])
        else $error("word access on odd address");
    a_long_align: assert property (memReq && memSize == 2'h2 |-> memAddr[1:0] == 2'h0)
        else $error("long access not on a four byte boundary");
    a_size_legal: assert property (memReq |-> memSize != 2'h3)
        else $error("reserved size on the memory bus");
    a_req_hold: assert property (s_waiting |=> memReq && $stable(memAddr) && $stable(memSize))
        else $error("access dropped or changed before done");
    a_req_release: assert property (memReq && memDone |-> s_released)
        else $error("access not released after done");
    // Attribute bits move only as the tail of a register bus write
    a_attr_change: assert property ($changed(memAttr) |-> $past(wvalid) || $past(wvalid, 2) || $past(wvalid, 3))
        else $error("attributes changed without a write");
    a_regwr_halted: assert property (regWrEn |-> cpuHalted)
        else $error("register written while core runs");
    a_regwr_pulse: assert property (regWrEn |=> !regWrEn)
        else $error("register write pulse too long");
endmodule

bind dbgm_cmd dbgm_cmd_monitor u_mon (.clock(clock), .arst_n(arst_n), .wvalid(wvalid), .cpuHalted(cpuHalted),
    .regWrEn(regWrEn), .memReq(memReq), .memDone(memDone), .memSize(memSize), .memAddr(memAddr),
    .memAttr(memAttr));

// >>> verif/dbgm_mem_model.sv
// Behavioural memory on the far side of the engine's system bus port.
// Assumes one access at a time, held until memDone.
`timescale 1ns/1ps

module dbgm_mem_model (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        arst_n,
    // Access from the engine
    input  wire logic        memReq,
    input  wire logic        memWr,
    input  wire logic [31:0] memAddr,
    input  wire logic [31:0] memWrData,
    // Bench controls
    input  wire logic [7:0]  delay,
    input  wire logic [31:0] errAddr,
    // Answer and record
    output logic             memDone,
    output logic             memBusErr,
    output logic [31:0]      memRdData,
    output logic [31:0]      wrAddr,
    output logic [31:0]      wrData
);
    logic [7:0]  waitCnt;
    logic        served;
    logic [31:0] noise;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            {memDone, served, waitCnt, noise, wrAddr, wrData} <= '0;
        end else begin
            noise   <= noise + 32'h9e37_79b9;
            memDone <= 1'b0;
            if (!memReq) begin
                served  <= 1'b0;
                waitCnt <= 8'h0;
            end else if (!served && waitCnt >= delay) begin
                memDone <= 1'b1;
                served  <= 1'b1;
                wrAddr  <= memWr ? memAddr : wrAddr;
                wrData  <= memWr ? memWrData : wrData;
            end else if (!served) begin
                waitCnt <= waitCnt + 8'h1;
            end
        end
    end
    // Data and error mean nothing outside memDone, so they keep moving there
    assign memRdData = memDone ? memAddr ^ 32'hc3a5_5a3c : noise;
    assign memBusErr = memDone ? memAddr == errAddr : noise[0];
endmodule

// >>> verif/tb_top.sv
// Bench of the debug engine: serial host, AXI4-Lite master, memory model.
// Assumes dbgm_cmd, dbgm_mem_model and the bound checker are compiled first.
`timescale 1ns/1ps
`include "dbgm_consts.svh"
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin miscompares++; \
    $display("unexpected %s exp %h seen %h", n, e, s); end end

module tb_top
    import dbgm_pkg::*;
;
    localparam logic [16:0] NR  = `DBGM_RSP_NOTREADY;
    localparam logic [16:0] CP  = `DBGM_RSP_COMPLETE;
    localparam logic [16:0] BE  = `DBGM_RSP_BUSERR;
    localparam logic [16:0] IL  = `DBGM_RSP_ILLEGAL;
    localparam logic [15:0] NOP = `DBGM_OP_NOP;
    logic        clock = 1'b0, arst_n = 1'b0, cpuHalted = 1'b1, dsClk = 1'b0, dsIn = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0]  awaddr = 8'h0, araddr = 8'h0, delay = 8'h0;
    logic [3:0]  wstrb = 4'hf, regSel, sel;
    logic [31:0] wdata = 32'h0, errAddr = 32'h0, rnd = 32'h7d54_3c1c, regRdData, ptr, d;
    logic        awready, wready, bvalid, arready, rvalid, dsOut, regWrEn, memReq, memWr, memDone, memBusErr;
    logic [1:0]  bresp, rresp, memSize;
    logic [4:0]  memAttr, attr;
    logic [31:0] rdata, regWrData, memAddr, memWrData, memRdData, wrAddr, wrData;
    logic [16:0] rxWord, ex, expQ[$];
    logic [33:0] ea, axQ[$];
    logic [35:0] er, regQ[$];
    int          miscompares = 0, comparisons = 0;
    event        rxEv;

    dbgm_cmd DUT (.clock, .arst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
        .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .dsClk, .dsIn, .dsOut,
        .cpuHalted, .regWrEn, .regSel, .regWrData, .regRdData, .memReq, .memWr, .memAddr, .memSize, .memAttr,
        .memWrData, .memDone, .memBusErr, .memRdData);
    dbgm_mem_model mem (.clock, .arst_n, .memReq, .memWr, .memAddr, .memWrData, .delay, .errAddr, .memDone,
        .memBusErr, .memRdData, .wrAddr, .wrData);
    assign regRdData = {8{regSel}} ^ 32'h1234_5678;

    initial forever #5 clock = ~clock;

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic report_and_stop;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // One 17-bit frame; the link clock rests low between frames
    task automatic xfer(input logic [15:0] w, input logic [16:0] e);
        expQ.push_back(e);
        for (int i = 16; i >= 0; i--) begin
            dsClk <= 1'b0;
            dsIn  <= i == 16 ? 1'b0 : w[i];
            repeat (3) @(posedge clock);
            #1 rxWord[i] = dsOut;
            @(posedge clock);
            dsClk <= 1'b1;
            repeat (4) @(posedge clock);
        end
        dsClk <= 1'b0;
        repeat (4) @(posedge clock);
        -> rxEv;
    endtask

    task automatic axr(input logic [7:0] a, input logic [33:0] e);
        axQ.push_back(e);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge clock); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clock); while (rvalid !== 1'b1);
        rready  <= 1'b0;
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
        axQ.push_back({e, 32'h0});
        awaddr  <= a;
        wdata   <= v;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        fork
            begin do @(posedge clock); while (awready !== 1'b1); awvalid <= 1'b0; end
            begin do @(posedge clock); while (wready !== 1'b1); wvalid <= 1'b0; end
        join
        do @(posedge clock); while (bvalid !== 1'b1);
        bready  <= 1'b0;
    endtask

    task automatic settle;
        repeat (6) @(posedge clock);
        while (memReq !== 1'b0) @(posedge clock);
    endtask

    task automatic regrd(input logic [3:0] s);
        logic [31:0] v;
        v = {8{s}} ^ 32'h1234_5678;
        xfer({12'h218, s}, CP);
        xfer(NOP, {1'b0, v[31:16]});
        xfer(NOP, {1'b0, v[15:0]});
    endtask

    task automatic regwr(input logic [3:0] s, input logic [31:0] v, input logic h);
        cpuHalted <= h;
        if (h)
            regQ.push_back({s, v});
        xfer({12'h208, s}, CP);
        xfer(v[31:16], NR);
        xfer(v[15:0], NR);
        xfer(NOP, h ? CP : BE);
    endtask

    // Read or dump; a slow memory ends the access while one frame is still on the wire
    task automatic mrd(input logic [7:0] op, input logic [1:0] sz, input logic [31:0] a, input logic err, slow);
        logic [31:0] al, v;
        al = a & ~((32'h1 << sz) - 32'h1);
        v  = al ^ 32'hc3a5_5a3c;
        errAddr <= err ? al : ~al;
        delay   <= slow ? 8'h64 : {5'h0, rnd[2:0]};
        xfer({op, sz, 6'h0}, CP);
        if (op == `DBGM_OP_READ) begin
            xfer(a[31:16], NR);
            xfer(a[15:0], NR);
        end
        if (slow)
            xfer(NOP, NR);
        settle;
        if (err)
            xfer(NOP, BE);
        else if (sz == 2'h2) begin
            xfer(NOP, {1'b0, v[31:16]});
            xfer(NOP, {1'b0, v[15:0]});
        end else
            xfer(NOP, {1'b0, sz == 2'h0 ? {8'h0, v[7:0]} : v[15:0]});
        ptr = al + (32'h1 << sz);
    endtask

    task automatic mwr(input logic [7:0] op, input logic [1:0] sz, input logic [31:0] a, v, input logic err);
        logic [31:0] al, m;
        al = a & ~((32'h1 << sz) - 32'h1);
        m  = sz == 2'h2 ? 32'hffff_ffff : sz == 2'h1 ? 32'hffff : 32'hff;
        errAddr <= err ? al : ~al;
        xfer({op, sz, 6'h0}, CP);
        if (op == `DBGM_OP_WRITE) begin
            xfer(a[31:16], NR);
            xfer(a[15:0], NR);
        end
        if (sz == 2'h2)
            xfer(v[31:16], NR);
        xfer(v[15:0] & m[15:0], NR);
        settle;
        xfer(NOP, err ? BE : CP);
        if (!err)
            `CHK("memory write", {al, v & m}, {wrAddr, wrData & m})
        ptr = al + (32'h1 << sz);
    endtask

    initial forever begin
        @(rxEv);
        ex = expQ.pop_front();
        `CHK("dsOut frame", ex, rxWord)
    end

    always @(posedge clock) begin
        if (rvalid === 1'b1 && rready === 1'b1) begin
            ea = axQ.pop_front();
            `CHK("read channel", ea, {rresp, rdata})
        end
        if (bvalid === 1'b1 && bready === 1'b1) begin
            ea = axQ.pop_front();
            `CHK("write response", ea, {bresp, 32'h0})
        end
        if (regWrEn === 1'b1) begin
            er = regQ.pop_front();
            `CHK("register write", er, {regSel, regWrData})
        end
    end

    initial begin
        repeat (60000) @(posedge clock);
        miscompares++;
        report_and_stop;
    end

    initial begin
        repeat (4) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        axr(`DBGM_REG_ATTR, {2'h0, 32'h5});
        attr = rnd[4:0];
        axw(`DBGM_REG_ATTR, {27'h0, attr}, `DBGM_RESP_OKAY);
        axw(`DBGM_REG_PTR, rnd, `DBGM_RESP_SLVERR);
        axr(`DBGM_REG_ATTR, {29'h0, attr});
        axr(8'h0c, {`DBGM_RESP_SLVERR, 32'h0});
        `CHK("memAttr", attr, memAttr)
        sel = rnd[3:0];
        regrd(sel);
        rnd = lfsr(rnd);
        regwr(sel, rnd, 1'b1);
        regwr(~sel, ~rnd, 1'b0);
        cpuHalted <= 1'b1;
        xfer({`DBGM_OP_DUMP, 8'h0}, CP);
        xfer(NOP, IL);
        xfer({`DBGM_OP_READ, 8'hc0}, CP);
        xfer(NOP, IL);
        for (int k = 0; k < 3; k++) begin
            rnd = lfsr(rnd);
            mrd(`DBGM_OP_READ, k[1:0], rnd, 1'b0, k == 1);
            mrd(`DBGM_OP_DUMP, 2'(2 - k), ptr, 1'b0, 1'b0);
            mrd(`DBGM_OP_DUMP, k[1:0], ptr, 1'b0, 1'b0);
            axr(`DBGM_REG_PTR, {2'h0, ptr});
        end
        xfer({`DBGM_OP_FILL, 8'h0}, CP);
        xfer(NOP, IL);
        for (int k = 0; k < 3; k++) begin
            rnd = lfsr(rnd);
            d   = lfsr(rnd);
            mwr(`DBGM_OP_WRITE, k[1:0], rnd, d, 1'b0);
            mwr(`DBGM_OP_FILL, 2'(2 - k), ptr, ~d, 1'b0);
            axr(`DBGM_REG_PTR, {2'h0, ptr});
        end
        xfer({`DBGM_OP_DUMP, 8'h0}, CP);
        xfer(NOP, IL);
        mrd(`DBGM_OP_READ, 2'h0, rnd, 1'b1, 1'b0);
        mrd(`DBGM_OP_DUMP, 2'h0, ptr, 1'b1, 1'b0);
        mwr(`DBGM_OP_WRITE, 2'h1, d, rnd, 1'b1);
        mrd(`DBGM_OP_READ, 2'h2, 32'hffff_fffe, 1'b0, 1'b0);
        axr(`DBGM_REG_PTR, {2'h0, 32'h0});
        report_and_stop;
    end
endmodule
